/* rtl/arm_consts.svh */
`ifndef ARM_CONSTS_SVH
`define ARM_CONSTS_SVH

// Timing
`define CLK_PERIOD_NS 10
`define LINK_PULSE_NS 10000

// Arm count
`define ARM_COUNT_W 14
`define ARM_COUNT_MAX 9999
`define ARM_COUNT_RST 14'h0001
`define ARM_COUNT_INF 14'h0000

// Trigger link
`define LINK_LINES 6
`define LINK_IN_RST 3'h0
`define LINK_OUT_RST 3'h1

// Error codes
`define ERR_CODE_W 10
`define SAVED_STATE_ERR 10'h1fe
`define ERR_NONE 10'h000

`endif

/* rtl/arm_pkg.sv */
package arm_pkg;

  typedef enum logic [2:0] {
    SRC_MANUAL,
    SRC_IMMEDIATE,
    SRC_BUS,
    SRC_EXTERNAL,
    SRC_LINK,
    SRC_HOLD
  } arm_src_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM_WAIT,
    ST_SCAN
  } arm_state_t;

endpackage

/* rtl/arm_trigger_top.sv */
// Behaviour
// RULE_01: Arm source picks one of six events
// RULE_02: Immediate source enters scan layer at once
// RULE_03: Manual source advances on step key
// RULE_04: Step key also arms bus/external/link sources
// RULE_05: Bus source advances on bus trigger
// RULE_06: External source advances on external trigger
// RULE_07: Link source watches chosen line, pulses output
// RULE_08: Refuse link config with equal in/out lines
// RULE_09: Hold source never enters scan layer
// RULE_10: Arm count 1 to 9999, default one
// RULE_11: Stored count zero means infinite arming
// RULE_12: Infinite arming never ends on count
// RULE_13: Bypass skips first external/link arm wait
// RULE_14: Acceptor waits for event every pass
// RULE_15: One-closure mode allows one closed channel
// RULE_16: One-closure close picks lowest slot/channel
// RULE_17: Enabling one-closure mode clears stored patterns
// RULE_18: Refuse one-closure mode with two closed
// RULE_19: Restricted channels never close
// RULE_20: Newly restricted entry raises 510, clears list
// RULE_21: Spent finite count returns to idle
`timescale 1ns/1ns
`include "arm_consts.svh"
module arm_trigger_top
  import arm_pkg::*;
#(
  parameter int SLOT_COUNT = 2,
  parameter int SLOT_CHANS = 10,
  parameter int PAT_COUNT = 4,
  parameter int COUNT_MAX = `ARM_COUNT_MAX
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire arm_src_t arm_src_in,
  input wire logic bypass_en_in,
  input wire logic count_wr_in,
  input wire logic [`ARM_COUNT_W-1:0] arm_count_in,
  input wire logic initiate_in,
  input wire logic abort_in,
  input wire logic scan_done_in,
  input wire logic step_key_in,
  input wire logic bus_trig_in,
  input wire logic ext_trig_in,
  input wire logic [`LINK_LINES-1:0] link_lines_in,
  input wire logic link_cfg_wr_in,
  input wire logic [2:0] link_in_sel_in,
  input wire logic [2:0] link_out_sel_in,
  input wire logic chan_close_in,
  input wire logic chan_open_in,
  input wire logic one_closure_wr_in,
  input wire logic one_closure_val_in,
  input wire logic restrict_wr_in,
  input wire logic scan_list_wr_in,
  input wire logic pat_wr_in,
  input wire logic [SLOT_COUNT*SLOT_CHANS-1:0] chan_mask_in,
  input wire logic [(PAT_COUNT>1 ? $clog2(PAT_COUNT) : 1)-1:0] pat_idx_in,
  output logic scan_start_out,
  output logic arm_wait_out,
  output logic busy_out,
  output logic [`ARM_COUNT_W-1:0] arm_count_out,
  output logic [`ARM_COUNT_W-1:0] passes_left_out,
  output logic count_reject_out,
  output logic [`LINK_LINES-1:0] link_lines_out,
  output logic link_cfg_reject_out,
  output logic [2:0] link_in_sel_out,
  output logic [2:0] link_out_sel_out,
  output logic [SLOT_COUNT*SLOT_CHANS-1:0] closed_mask_out,
  output logic [SLOT_COUNT*SLOT_CHANS-1:0] restricted_mask_out,
  output logic [SLOT_COUNT*SLOT_CHANS-1:0] scan_list_out,
  output logic [SLOT_COUNT*SLOT_CHANS-1:0] pat_rd_mask_out,
  output logic one_closure_mode_out,
  output logic chan_refused_out,
  output logic err_valid_out,
  output logic [`ERR_CODE_W-1:0] err_code_out
);
  localparam int NUM_CHAN = SLOT_COUNT * SLOT_CHANS;
  localparam int PAT_W = PAT_COUNT > 1 ? $clog2(PAT_COUNT) : 1;
  localparam int LINES = `LINK_LINES;
  localparam int PULSE_CYC =
    (`LINK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int PCNT_W = $clog2(PULSE_CYC + 1);

  if (COUNT_MAX < 1 || COUNT_MAX >= (1 << `ARM_COUNT_W) ||
      NUM_CHAN < 2 || PAT_COUNT < 1 || PULSE_CYC < 8) begin : g_bad_cfg
    $error("arm_trigger_top: unsupported parameter values");
  end

  arm_state_t state_q, state_d;
  logic [LINES+1:0] pins_s, pins_prev_q, pins_rise;
  logic step_rise, ext_rise, link_sel_rise;
  logic [2:0] link_in_q, link_out_q;
  logic link_reject_q, link_cfg_bad;
  logic [`ARM_COUNT_W-1:0] count_q, passes_q;
  logic count_reject_q, infinite_q, first_pass_q;
  logic arm_event, bypass_now, go;
  logic scan_start_q, arm_wait_q, busy_q;
  logic [PCNT_W-1:0] pulse_cnt_q;
  logic [LINES-1:0] link_drive_q;

  // Pins cross in through two flops before edge detection
  sync2 #(
    .WIDTH(LINES + 2)
  ) u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({step_key_in, ext_trig_in, link_lines_in}),
    .sync_out(pins_s)
  );

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pins_prev_q <= '0;
    end else begin
      pins_prev_q <= pins_s;
    end
  end

  assign pins_rise = pins_s & ~pins_prev_q;
  assign step_rise = pins_rise[LINES+1];
  assign ext_rise = pins_rise[LINES];
  assign link_sel_rise = pins_rise[link_in_q]; // [RULE_07]

  // Trigger link line selection
  assign link_cfg_bad = link_in_sel_in == link_out_sel_in ||
                        link_in_sel_in >= 3'(LINES) ||
                        link_out_sel_in >= 3'(LINES);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      link_in_q <= `LINK_IN_RST;
      link_out_q <= `LINK_OUT_RST;
      link_reject_q <= 1'b0;
    end else if (link_cfg_wr_in) begin
      // A bad pair keeps the previous valid selection
      link_reject_q <= link_cfg_bad; // [RULE_08]
      if (!link_cfg_bad) begin
        link_in_q <= link_in_sel_in;
        link_out_q <= link_out_sel_in;
      end
    end
  end

  // Programmed arm count
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_q <= `ARM_COUNT_RST; // [RULE_10]
      count_reject_q <= 1'b0;
    end else if (count_wr_in) begin
      count_reject_q <= arm_count_in > `ARM_COUNT_W'(COUNT_MAX);
      if (arm_count_in <= `ARM_COUNT_W'(COUNT_MAX)) begin
        count_q <= arm_count_in; // [RULE_10]
      end
    end
  end

  // Arm event selection
  assign bypass_now = bypass_en_in && first_pass_q; // [RULE_13] [RULE_14]

  always_comb begin
    arm_event = 1'b0;
    case (arm_src_in) // [RULE_01]
      SRC_IMMEDIATE: arm_event = 1'b1; // [RULE_02]
      SRC_MANUAL: arm_event = step_rise; // [RULE_03]
      SRC_BUS: arm_event = step_rise || bus_trig_in; // [RULE_04] [RULE_05]
      SRC_EXTERNAL: begin
        arm_event = step_rise || ext_rise || bypass_now; // [RULE_06]
      end
      SRC_LINK: begin
        arm_event = step_rise || link_sel_rise || bypass_now; // [RULE_07]
      end
      SRC_HOLD: arm_event = 1'b0; // [RULE_09]
      default: arm_event = 1'b0;
    endcase
  end

  assign go = state_q == ST_ARM_WAIT && arm_event && !abort_in;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (initiate_in && !abort_in) state_d = ST_ARM_WAIT;
      end
      ST_ARM_WAIT: begin
        if (abort_in) state_d = ST_IDLE;
        else if (go) state_d = ST_SCAN;
      end
      ST_SCAN: begin
        if (abort_in) begin
          state_d = ST_IDLE;
        end else if (scan_done_in) begin
          if (!infinite_q && passes_q == `ARM_COUNT_RST) begin
            state_d = ST_IDLE; // [RULE_21]
          end else begin
            state_d = ST_ARM_WAIT; // [RULE_12]
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      arm_wait_q <= 1'b0;
      busy_q <= 1'b0;
      scan_start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      arm_wait_q <= state_d == ST_ARM_WAIT;
      busy_q <= state_d != ST_IDLE;
      scan_start_q <= go;
    end
  end

  // Pass counter, loaded at initiate
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      passes_q <= `ARM_COUNT_RST;
      infinite_q <= 1'b0;
    end else if (state_q == ST_IDLE && initiate_in && !abort_in) begin
      passes_q <= count_q;
      infinite_q <= count_q == `ARM_COUNT_INF; // [RULE_11]
    end else if (state_q == ST_SCAN && scan_done_in && !abort_in &&
                 !infinite_q) begin
      passes_q <= passes_q - `ARM_COUNT_W'(1); // [RULE_10]
    end
  end

  // Bypass applies to the first pass after initiate only
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      first_pass_q <= 1'b0;
    end else if (state_q == ST_IDLE && initiate_in) begin
      first_pass_q <= 1'b1;
    end else if (go) begin
      first_pass_q <= 1'b0; // [RULE_13]
    end
  end

  // Outgoing link pulse; long enough for slow receivers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pulse_cnt_q <= '0;
    end else if (go) begin
      pulse_cnt_q <= PCNT_W'(PULSE_CYC);
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - PCNT_W'(1);
    end
  end

  for (genvar i = 0; i < LINES; i++) begin : g_link_out
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        link_drive_q[i] <= 1'b0;
      end else begin
        link_drive_q[i] <= (go || pulse_cnt_q > PCNT_W'(1)) &&
                           link_out_q == 3'(i); // [RULE_07]
      end
    end
  end

  // Channel guard
  guard_if #(
    .NUM_CHAN(NUM_CHAN),
    .PAT_W(PAT_W)
  ) gi ();

  assign gi.close_req = chan_close_in;
  assign gi.open_req = chan_open_in;
  assign gi.mode_wr = one_closure_wr_in;
  assign gi.mode_val = one_closure_val_in;
  assign gi.restrict_wr = restrict_wr_in;
  assign gi.scan_wr = scan_list_wr_in;
  assign gi.pat_wr = pat_wr_in;
  assign gi.mask = chan_mask_in;
  assign gi.pat_idx = pat_idx_in;

  channel_guard #(
    .NUM_CHAN(NUM_CHAN),
    .PAT_COUNT(PAT_COUNT),
    .PAT_W(PAT_W)
  ) u_guard (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .gi(gi)
  );

  assign scan_start_out = scan_start_q;
  assign arm_wait_out = arm_wait_q;
  assign busy_out = busy_q;
  assign arm_count_out = count_q;
  assign passes_left_out = passes_q;
  assign count_reject_out = count_reject_q;
  assign link_lines_out = link_drive_q;
  assign link_cfg_reject_out = link_reject_q;
  assign link_in_sel_out = link_in_q;
  assign link_out_sel_out = link_out_q;
  assign closed_mask_out = gi.closed;
  assign restricted_mask_out = gi.restricted;
  assign scan_list_out = gi.scan_list;
  assign pat_rd_mask_out = gi.pat_rd;
  assign one_closure_mode_out = gi.one_closure;
  assign chan_refused_out = gi.refused;
  assign err_valid_out = gi.err_valid;
  assign err_code_out = gi.err_code;

  // Checks
  logic [NUM_CHAN-1:0] chk_allowed, chk_lowest;
  logic chk_waiting;
  assign chk_allowed = chan_mask_in & ~gi.restricted;
  assign chk_lowest = chk_allowed & (~chk_allowed + 1'b1);
  assign chk_waiting = state_q == ST_ARM_WAIT && !abort_in;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence link_pulse_s;
    (|link_drive_q) [*8];
  endsequence

  sequence mode_on_s;
    gi.one_closure ##1 (gi.pat_rd == '0 || $past(pat_wr_in));
  endsequence

  chk_immediate_go: assert property ( // [RULE_02]
    chk_waiting && arm_src_in == SRC_IMMEDIATE |=>
      scan_start_q && state_q == ST_SCAN)
    else $error("immediate source did not enter scan layer");
  chk_manual_step: assert property ( // [RULE_03]
    chk_waiting && arm_src_in == SRC_MANUAL && step_rise |=> scan_start_q)
    else $error("step key ignored with manual source");
  chk_step_other: assert property ( // [RULE_04]
    chk_waiting && step_rise && (arm_src_in == SRC_BUS ||
      arm_src_in == SRC_EXTERNAL || arm_src_in == SRC_LINK) |=>
      scan_start_q)
    else $error("step key ignored with event source");
  chk_bus_trigger: assert property ( // [RULE_05]
    chk_waiting && arm_src_in == SRC_BUS && bus_trig_in |=> scan_start_q)
    else $error("bus trigger did not arm");
  chk_ext_trigger: assert property ( // [RULE_06]
    chk_waiting && arm_src_in == SRC_EXTERNAL && ext_rise |=> scan_start_q)
    else $error("external trigger did not arm");
  chk_link_pulse: assert property ( // [RULE_07]
    chk_waiting && arm_src_in == SRC_LINK && link_sel_rise |=>
      scan_start_q ##0 link_pulse_s)
    else $error("link trigger did not arm or pulse out");
  chk_link_reject: assert property ( // [RULE_08]
    link_cfg_wr_in && link_in_sel_in == link_out_sel_in |=>
      link_reject_q && $stable(link_in_q) && $stable(link_out_q))
    else $error("equal link lines were accepted");
  chk_hold_blocks: assert property ( // [RULE_09]
    state_q == ST_ARM_WAIT && arm_src_in == SRC_HOLD |=> !scan_start_q)
    else $error("hold source let operation pass");
  chk_infinite_loop: assert property ( // [RULE_11] [RULE_12]
    state_q == ST_SCAN && infinite_q && scan_done_in && !abort_in |=>
      state_q == ST_ARM_WAIT)
    else $error("infinite arming terminated");
  chk_count_end: assert property ( // [RULE_21]
    state_q == ST_SCAN && !infinite_q && passes_q == `ARM_COUNT_RST &&
      scan_done_in && !abort_in |=> state_q == ST_IDLE && !busy_q)
    else $error("spent arm count did not return to idle");
  chk_bypass_first: assert property ( // [RULE_13]
    chk_waiting && first_pass_q && bypass_en_in &&
      arm_src_in == SRC_EXTERNAL |=> scan_start_q && !first_pass_q)
    else $error("bypass did not skip first arm event");
  chk_acceptor_wait: assert property ( // [RULE_14]
    state_q == ST_ARM_WAIT && !bypass_en_in &&
      arm_src_in == SRC_EXTERNAL && !ext_rise && !step_rise |=>
      !scan_start_q)
    else $error("acceptor passed without an event");
  chk_single_closed: assert property ( // [RULE_15]
    gi.one_closure |-> $onehot0(gi.closed))
    else $error("more than one channel closed in one-closure mode");
  chk_lowest_close: assert property ( // [RULE_16]
    gi.one_closure && chan_close_in && !restrict_wr_in &&
      !one_closure_wr_in && chk_lowest != '0 |=>
      gi.closed == $past(chk_lowest))
    else $error("one-closure close did not pick lowest channel");
  chk_mode_clears: assert property ( // [RULE_17]
    one_closure_wr_in && one_closure_val_in && !restrict_wr_in &&
      $onehot0(gi.closed) && !pat_wr_in |=> mode_on_s)
    else $error("one-closure enable left stored patterns");
  chk_mode_refuse: assert property ( // [RULE_18]
    one_closure_wr_in && one_closure_val_in && !restrict_wr_in &&
      !$onehot0(gi.closed) |=> gi.refused && $stable(gi.one_closure))
    else $error("one-closure enabled with several channels closed");
  chk_restrict_close: assert property ( // [RULE_19]
    chan_close_in && !restrict_wr_in && !one_closure_wr_in |=>
      ((gi.closed & ~$past(gi.closed)) & gi.restricted) == '0)
    else $error("restricted channel was closed");
  chk_saved_err: assert property ( // [RULE_20]
    restrict_wr_in && |(chan_mask_in & gi.scan_list) |=>
      gi.err_valid && gi.err_code == `SAVED_STATE_ERR &&
      gi.scan_list == '0)
    else $error("restricted scan entry not flagged and cleared");
endmodule

/* rtl/channel_guard.sv */
`timescale 1ns/1ns
`include "arm_consts.svh"
module channel_guard #(
  parameter int NUM_CHAN = 20,
  parameter int PAT_COUNT = 4,
  parameter int PAT_W = 2
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  guard_if.guard gi
);
  logic [NUM_CHAN-1:0] closed_q, restrict_q, scan_q, pat_rd_q;
  logic [NUM_CHAN-1:0] pat_q [PAT_COUNT];
  logic [NUM_CHAN-1:0] allowed, pick;
  logic [PAT_COUNT-1:0] pat_hit;
  logic one_q, refused_q, err_q, multi, scan_hit;
  logic t_rst, t_mode, t_close, t_open, t_store, mode_ok;
  logic [`ERR_CODE_W-1:0] code_q;

  // Restriction first, then mode, then close over open; list and pattern writes yield only to restriction and mode
  assign t_rst = gi.restrict_wr;
  assign t_mode = gi.mode_wr && !t_rst;
  assign t_close = gi.close_req && !t_rst && !gi.mode_wr;
  assign t_open = gi.open_req && !t_rst && !gi.mode_wr && !gi.close_req;
  assign t_store = !t_rst && !gi.mode_wr;
  assign allowed = gi.mask & ~restrict_q;
  assign pick = allowed & (~allowed + 1'b1);
  assign multi = |(closed_q & (closed_q - 1'b1));
  assign mode_ok = t_mode && gi.mode_val && !multi;
  assign scan_hit = |(scan_q & gi.mask);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      closed_q <= '0;
    end else if (t_close && one_q) begin
      // Index order is slot-major, so lowest bit is lowest slot/channel
      if (pick != '0) closed_q <= pick; // [RULE_15] [RULE_16] [RULE_19]
    end else if (t_close) begin
      closed_q <= closed_q | allowed; // [RULE_19]
    end else if (t_open) begin
      closed_q <= closed_q & ~gi.mask;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      one_q <= 1'b0;
    end else if (t_mode && !(gi.mode_val && multi)) begin
      one_q <= gi.mode_val; // [RULE_18]
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      restrict_q <= '0;
      scan_q <= '0;
    end else if (t_rst) begin
      restrict_q <= gi.mask;
      if (scan_hit) scan_q <= '0; // [RULE_20]
    end else if (t_store && gi.scan_wr) begin
      scan_q <= gi.mask;
    end
  end

  for (genvar p = 0; p < PAT_COUNT; p++) begin : g_pat
    assign pat_hit[p] = |(pat_q[p] & gi.mask);
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        pat_q[p] <= '0;
      end else if (mode_ok || (t_rst && pat_hit[p])) begin
        pat_q[p] <= '0; // [RULE_17] [RULE_20]
      end else if (t_store && gi.pat_wr && gi.pat_idx == PAT_W'(p)) begin
        pat_q[p] <= gi.mask;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      err_q <= 1'b0;
      code_q <= `ERR_NONE;
      refused_q <= 1'b0;
      pat_rd_q <= '0;
    end else begin
      err_q <= t_rst && (scan_hit || |pat_hit); // [RULE_20]
      code_q <= (t_rst && (scan_hit || |pat_hit)) ? `SAVED_STATE_ERR
                                                  : `ERR_NONE;
      refused_q <= (t_close && |(gi.mask & restrict_q)) ||
                   (t_mode && gi.mode_val && multi); // [RULE_18] [RULE_19]
      pat_rd_q <= (int'(gi.pat_idx) < PAT_COUNT) ? pat_q[gi.pat_idx] : '0;
    end
  end

  assign gi.closed = closed_q;
  assign gi.restricted = restrict_q;
  assign gi.scan_list = scan_q;
  assign gi.pat_rd = pat_rd_q;
  assign gi.one_closure = one_q;
  assign gi.refused = refused_q;
  assign gi.err_valid = err_q;
  assign gi.err_code = code_q;
endmodule

/* rtl/guard_if.sv */
`timescale 1ns/1ns
`include "arm_consts.svh"
interface guard_if #(
  parameter int NUM_CHAN = 20,
  parameter int PAT_W = 2
);
  logic close_req;
  logic open_req;
  logic mode_wr;
  logic mode_val;
  logic restrict_wr;
  logic scan_wr;
  logic pat_wr;
  logic [NUM_CHAN-1:0] mask;
  logic [PAT_W-1:0] pat_idx;
  logic [NUM_CHAN-1:0] closed;
  logic [NUM_CHAN-1:0] restricted;
  logic [NUM_CHAN-1:0] scan_list;
  logic [NUM_CHAN-1:0] pat_rd;
  logic one_closure;
  logic refused;
  logic err_valid;
  logic [`ERR_CODE_W-1:0] err_code;

  modport ctrl (
    output close_req, open_req, mode_wr, mode_val, restrict_wr,
    output scan_wr, pat_wr, mask, pat_idx,
    input closed, restricted, scan_list, pat_rd, one_closure,
    input refused, err_valid, err_code
  );
  modport guard (
    input close_req, open_req, mode_wr, mode_val, restrict_wr,
    input scan_wr, pat_wr, mask, pat_idx,
    output closed, restricted, scan_list, pat_rd, one_closure,
    output refused, err_valid, err_code
  );
endinterface

/* rtl/sync2.sv */
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* testbench/test_arm_layer_trigger_and_channel_guard.sv */
`timescale 1ns/1ns
`include "arm_consts.svh"
module test_arm_layer_trigger_and_channel_guard
  import arm_pkg::*;
  ;
  logic clk_in, sys_rst_in, bypass_en_in, count_wr_in, initiate_in;
  logic abort_in, scan_done_in, step_key_in, bus_trig_in, ext_trig_in;
  logic link_cfg_wr_in, chan_close_in, chan_open_in, one_closure_wr_in;
  logic one_closure_val_in, restrict_wr_in, scan_list_wr_in, pat_wr_in;
  arm_src_t arm_src_in;
  logic [13:0] arm_count_in, arm_count_out, passes_left_out;
  logic [5:0] link_lines_in, link_lines_out;
  logic [2:0] link_in_sel_in, link_out_sel_in;
  logic [2:0] link_in_sel_out, link_out_sel_out;
  logic [19:0] chan_mask_in, closed_mask_out, restricted_mask_out;
  logic [19:0] scan_list_out, pat_rd_mask_out;
  logic [1:0] pat_idx_in;
  logic scan_start_out, arm_wait_out, busy_out, count_reject_out;
  logic link_cfg_reject_out, one_closure_mode_out, chan_refused_out;
  logic err_valid_out;
  logic [9:0] err_code_out;
  int num_errors = 0;
  int samples_checked = 0;

  trig_partner pm (.clk_in, .step_key_out(step_key_in),
    .bus_trig_out(bus_trig_in), .ext_trig_out(ext_trig_in),
    .link_lines_out(link_lines_in));

  arm_trigger_top uut (.clk_in, .sys_rst_in, .arm_src_in, .bypass_en_in,
    .count_wr_in, .arm_count_in, .initiate_in, .abort_in, .scan_done_in,
    .step_key_in, .bus_trig_in, .ext_trig_in, .link_lines_in,
    .link_cfg_wr_in, .link_in_sel_in, .link_out_sel_in, .chan_close_in,
    .chan_open_in, .one_closure_wr_in, .one_closure_val_in,
    .restrict_wr_in, .scan_list_wr_in, .pat_wr_in, .chan_mask_in,
    .pat_idx_in, .scan_start_out, .arm_wait_out, .busy_out,
    .arm_count_out, .passes_left_out, .count_reject_out, .link_lines_out,
    .link_cfg_reject_out, .link_in_sel_out, .link_out_sel_out,
    .closed_mask_out, .restricted_mask_out, .scan_list_out,
    .pat_rd_mask_out, .one_closure_mode_out, .chan_refused_out,
    .err_valid_out, .err_code_out);

  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // Idle edge first, so a strobe never rises in the step it fell
  task automatic pulse(ref logic s);
    tick(1);
    s = 1;
    tick(1);
    s = 0;
  endtask

  // Watches a bounded window; a missed pulse counts as no pass
  task automatic go(input int k, input int ln, input bit exp);
    bit got;
    got = 0;
    fork
      if (k != 0) pm.fire(k, ln);
      repeat (12) begin
        tick(1);
        if (scan_start_out === 1'b1) got = 1;
      end
    join
    chk(got, exp, "arm pass");
  endtask

  task automatic wcount(input logic [13:0] v);
    arm_count_in = v;
    pulse(count_wr_in);
  endtask

  task automatic lcfg(input logic [2:0] a, b);
    link_in_sel_in = a;
    link_out_sel_in = b;
    pulse(link_cfg_wr_in);
  endtask

  task automatic gcmd(input int k, input logic [19:0] m);
    tick(1);
    chan_mask_in = m;
    one_closure_val_in = 1;
    case (k)
      0: restrict_wr_in = 1;
      1: one_closure_wr_in = 1;
      2: chan_close_in = 1;
      3: chan_open_in = 1;
      4: scan_list_wr_in = 1;
      default: pat_wr_in = 1;
    endcase
    tick(1);
    {restrict_wr_in, one_closure_wr_in, chan_close_in, chan_open_in,
     scan_list_wr_in, pat_wr_in} = '0;
  endtask

  task automatic t_arm;
    arm_src_t s[6] = '{SRC_BUS, SRC_BUS, SRC_EXTERNAL, SRC_EXTERNAL,
                       SRC_LINK, SRC_MANUAL};
    int k[6] = '{2, 1, 3, 2, 1, 3};
    bit e[6] = '{1, 1, 1, 0, 1, 0};
    chk(arm_count_out, 1, "count reset");
    arm_src_in = SRC_IMMEDIATE;
    pulse(initiate_in);
    go(0, 0, 1);
    chk(link_lines_out, 6'h02, "link out");
    pulse(scan_done_in);
    chk(busy_out, 0, "spent count");
    arm_src_in = SRC_HOLD;
    pulse(initiate_in);
    chk(arm_wait_out, 1, "arm wait");
    go(1, 0, 0);
    arm_src_in = SRC_MANUAL;
    go(1, 0, 1);
    pulse(scan_done_in);
    for (int i = 0; i < 6; i++) begin
      arm_src_in = s[i];
      pulse(initiate_in);
      go(k[i], 0, e[i]);
      if (e[i]) pulse(scan_done_in);
      else pulse(abort_in);
    end
  endtask

  task automatic t_link;
    lcfg(3'h2, 3'h2);
    chk(link_cfg_reject_out, 1, "same line");
    chk(link_in_sel_out, 0, "kept line");
    lcfg(3'h3, 3'h5);
    chk(link_cfg_reject_out, 0, "good cfg");
    chk(link_out_sel_out, 3'h5, "out sel");
    arm_src_in = SRC_LINK;
    pulse(initiate_in);
    go(4, 1, 0);
    go(4, 3, 1);
    chk(link_lines_out[5], 1, "out line");
    pulse(scan_done_in);
  endtask

  task automatic t_count;
    wcount(14'h2710);
    chk(count_reject_out, 1, "count over");
    wcount(14'h270f);
    chk(arm_count_out, 14'h270f, "count max");
    wcount(14'h0002);
    bypass_en_in = 1;
    arm_src_in = SRC_EXTERNAL;
    pulse(initiate_in);
    go(0, 0, 1);
    pulse(scan_done_in);
    chk(passes_left_out, 1, "passes left");
    go(0, 0, 0);
    go(3, 0, 1);
    pulse(scan_done_in);
    chk(busy_out, 0, "two passes");
    bypass_en_in = 0;
    pulse(initiate_in);
    go(0, 0, 0);
    pulse(abort_in);
    wcount(14'h0000);
    arm_src_in = SRC_IMMEDIATE;
    pulse(initiate_in);
    repeat (3) begin
      go(0, 0, 1);
      pulse(scan_done_in);
    end
    chk(busy_out, 1, "infinite");
    pulse(abort_in);
  endtask

  task automatic t_guard;
    gcmd(4, 20'h00006);
    pat_idx_in = 1;
    gcmd(5, 20'h00004);
    gcmd(0, 20'h00004);
    chk(err_valid_out, 1, "err pulse");
    chk(err_code_out, `SAVED_STATE_ERR, "err code");
    chk(scan_list_out, 0, "list cleared");
    chk(restricted_mask_out, 20'h00004, "restrict list");
    tick(1);
    chk(pat_rd_mask_out, 0, "pattern cleared");
    gcmd(2, 20'h00004);
    chk(chan_refused_out, 1, "restricted");
    gcmd(2, 20'h00006);
    chk(closed_mask_out, 20'h00002, "partial close");
    gcmd(2, 20'h00008);
    gcmd(1, 20'h00000);
    chk(chan_refused_out, 1, "mode refused");
    chk(one_closure_mode_out, 0, "mode kept");
    gcmd(3, 20'hfffff);
    pat_idx_in = 0;
    gcmd(5, 20'h00003);
    gcmd(1, 20'h00000);
    chk(one_closure_mode_out, 1, "mode on");
    tick(1);
    chk(pat_rd_mask_out, 0, "patterns wiped");
    gcmd(2, 20'h01820);
    chk(closed_mask_out, 20'h00020, "lowest");
    gcmd(2, 20'h00100);
    chk(closed_mask_out, 20'h00100, "single");
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    summarize;
  end

  initial begin
    {bypass_en_in, count_wr_in, initiate_in, abort_in, scan_done_in} = '0;
    {link_cfg_wr_in, chan_close_in, chan_open_in, one_closure_wr_in} = '0;
    {one_closure_val_in, restrict_wr_in, scan_list_wr_in, pat_wr_in} = '0;
    {arm_count_in, link_in_sel_in, link_out_sel_in} = '0;
    {chan_mask_in, pat_idx_in} = '0;
    arm_src_in = SRC_HOLD;
    sys_rst_in = 1;
    tick(5);
    sys_rst_in = 0;
    tick(3);
    t_arm;
    t_link;
    t_count;
    t_guard;
    summarize;
  end
endmodule

/* testbench/trig_partner.sv */
`timescale 1ns/1ns
module trig_partner (
  input wire logic clk_in,
  output logic step_key_out,
  output logic bus_trig_out,
  output logic ext_trig_out,
  output logic [5:0] link_lines_out
);
  initial begin
    {step_key_out, bus_trig_out, ext_trig_out, link_lines_out} = '0;
  end
  // Step, external and link pins held 4 edges so the synchronisers see a settled level; bus trigger held 1 edge
  task automatic fire(input int kind, input int line);
    @(posedge clk_in);
    #1;
    case (kind)
      1: step_key_out = 1'b1;
      2: bus_trig_out = 1'b1;
      3: ext_trig_out = 1'b1;
      default: link_lines_out[line] = 1'b1;
    endcase
    if (kind == 2) begin
      @(posedge clk_in);
      #1;
      bus_trig_out = 1'b0;
    end else begin
      repeat (4) @(posedge clk_in);
      #1;
      {step_key_out, ext_trig_out, link_lines_out} = '0;
    end
  endtask
endmodule
